// file: logic/vst_trigger.sv
`timescale 1ns/1ps
`include "vst_params.svh"

module vst_trigger
   import vst_pkg::*;
#(
   parameter int NCH      = 4,
   parameter int AUTO_CYC = `VST_AUTO_US * 1000 / `VST_CLK_NS
) (
   // Clock and reset
   input  wire logic           ref_clk_in,
   input  wire logic           resetn_in,
   // Sync slicer levels, high while below the sync threshold
   input  wire logic [NCH-1:0] sync_slice_in,
   // Configuration
   input  wire vst_cfg_s       cfg_in,
   input  wire logic           period_wr_in,
   input  wire logic [16:0]    period_ns_in,
   input  wire logic           rate_wr_in,
   input  wire vst_rate_e      rate_in,
   input  wire logic           holdoff_wr_in,
   input  wire logic [23:0]    holdoff_cyc_in,
   // Trigger and acquisition
   output logic                trig_out,
   output logic                acq_start_out,
   output logic                auto_fired_out,
   output logic                armed_out,
   output logic                field_odd_out,
   // Status
   output vst_rate_e           rate_out,
   output logic [16:0]         period_ns_out,
   output logic [23:0]         holdoff_cyc_out
);

   localparam int          PH_W     = 12;
   localparam logic [16:0] P_MIN    = 17'(`VST_PERIOD_MIN_NS);
   localparam logic [16:0] P_MAX    = 17'(`VST_PERIOD_MAX_NS);
   localparam logic [16:0] R1_MIN   = 17'(`VST_RATE1_MIN_NS);
   localparam logic [16:0] R2_MIN   = 17'(`VST_RATE2_MIN_NS);
   localparam logic [16:0] R3_MIN   = 17'(`VST_RATE3_MIN_NS);
   localparam logic [16:0] R4_MIN   = 17'(`VST_RATE4_MIN_NS);
   localparam logic [16:0] CLK_NS   = 17'(`VST_CLK_NS);
   localparam logic [23:0] HO_525_1 = 24'(`VST_HO_525_F1_US * 1000 / `VST_CLK_NS);
   localparam logic [23:0] HO_525_2 = 24'(`VST_HO_525_F2_US * 1000 / `VST_CLK_NS);
   localparam logic [23:0] HO_625_1 = 24'(`VST_HO_625_F1_US * 1000 / `VST_CLK_NS);
   localparam logic [23:0] HO_625_2 = 24'(`VST_HO_625_F2_US * 1000 / `VST_CLK_NS);
   localparam logic [23:0] HO_CUST  = 24'(`VST_HO_CUST_US * 1000 / `VST_CLK_NS);
   localparam logic [PH_W-1:0] LINE_525 = PH_W'(`VST_LINE_NS_525 / `VST_CLK_NS);
   localparam logic [PH_W-1:0] LINE_625 = PH_W'(`VST_LINE_NS_625 / `VST_CLK_NS);

   if (NCH != 2 && NCH != 4) begin : g_bad_nch
      $error("vst_trigger: NCH must be 2 or 4");
   end
   if (AUTO_CYC < 1 || AUTO_CYC > 32'h00ff_ffff) begin : g_bad_auto
      $error("vst_trigger: AUTO_CYC must fit 24 bits");
   end

   vst_state_e      state_q;
   vst_rate_e       rate_q;
   logic [16:0]     period_q;
   logic [16:0]     period_clamp;
   logic [23:0]     holdoff_q;
   logic [23:0]     hold_cnt_q;
   logic [23:0]     auto_cnt_q;
   logic [19:0]     dly_cnt_q;
   logic            want_odd_q;
   vst_class_e      prev_class_q;
   logic            prev_f2_q;
   logic            sel_f2;
   logic            sync_lvl;
   logic [PH_W-1:0] line_cyc;
   logic            hs;
   logic            vs;
   logic            fo;
   logic            field_ok;
   logic            event_ok;
   logic            dly_done;
   logic            auto_due;

   function automatic vst_rate_e rate_of(input logic [16:0] p);
      if (p >= R1_MIN)
         return VST_RATE_1;
      else if (p >= R2_MIN)
         return VST_RATE_2;
      else if (p >= R3_MIN)
         return VST_RATE_3;
      else
         return VST_RATE_4;
   endfunction : rate_of

   function automatic logic [16:0] rate_min(input vst_rate_e r);
      unique case (r)
         VST_RATE_1: return R1_MIN;
         VST_RATE_2: return R2_MIN;
         VST_RATE_3: return R3_MIN;
         VST_RATE_4: return R4_MIN;
      endcase
   endfunction : rate_min

   always_comb begin
      sync_lvl = sync_slice_in[cfg_in.src_sel % NCH] ^ cfg_in.sync_pos;
   end

   always_comb begin
      unique case (cfg_in.class_sel)
         VST_CLASS_525:    line_cyc = LINE_525;
         VST_CLASS_PAL,
         VST_CLASS_SECAM:  line_cyc = LINE_625;
         VST_CLASS_CUSTOM: line_cyc = PH_W'(period_q / CLK_NS);
      endcase
   end

   vst_sync_sep #(
      .PH_W (PH_W)
   ) u_sep (
      .ref_clk_in    (ref_clk_in),
      .resetn_in     (resetn_in),
      .sync_lvl_in   (sync_lvl),
      .line_cyc_in   (line_cyc),
      .hsync_out     (hs),
      .vsync_out     (vs),
      .field_odd_out (fo)
   );

   always_comb begin
      if (period_ns_in < P_MIN)
         period_clamp = P_MIN;
      else if (period_ns_in > P_MAX)
         period_clamp = P_MAX;
      else
         period_clamp = period_ns_in;
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         period_q <= 17'(`VST_PERIOD_RST_NS);
         rate_q   <= VST_RATE_1;
      end else if (period_wr_in) begin
         period_q <= period_clamp;
         rate_q   <= rate_of(period_clamp);
      end else if (rate_wr_in) begin
         rate_q <= rate_in;
         if (rate_of(period_q) != rate_in)
            period_q <= rate_min(rate_in);
      end
   end

   // Field two is the even field or interlaced field two.
   always_comb begin
      if (cfg_in.class_sel == VST_CLASS_CUSTOM)
         sel_f2 = cfg_in.ilace_sel == VST_ILACE_F2;
      else
         sel_f2 = cfg_in.field_sel == VST_FIELD_EVEN;
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         holdoff_q    <= HO_525_1;
         prev_class_q <= VST_CLASS_525;
         prev_f2_q    <= 1'b0;
      end else begin
         prev_class_q <= cfg_in.class_sel;
         prev_f2_q    <= sel_f2;
         if (holdoff_wr_in)
            holdoff_q <= (holdoff_cyc_in == '0) ? 24'h00_0001 : holdoff_cyc_in;
         else if (prev_class_q != cfg_in.class_sel || prev_f2_q != sel_f2) begin
            unique case (cfg_in.class_sel)
               VST_CLASS_525:    holdoff_q <= sel_f2 ? HO_525_2 : HO_525_1;
               VST_CLASS_PAL,
               VST_CLASS_SECAM:  holdoff_q <= sel_f2 ? HO_625_2 : HO_625_1;
               VST_CLASS_CUSTOM: holdoff_q <= HO_CUST;
            endcase
         end
      end
   end

   always_comb begin
      if (cfg_in.class_sel == VST_CLASS_CUSTOM) begin
         unique case (cfg_in.ilace_sel)
            VST_ILACE_F1: field_ok = fo;
            VST_ILACE_F2: field_ok = ~fo;
            default:      field_ok = 1'b1;
         endcase
      end else begin
         unique case (cfg_in.field_sel)
            VST_FIELD_ODD:  field_ok = fo;
            VST_FIELD_EVEN: field_ok = ~fo;
            default:        field_ok = fo == want_odd_q;
         endcase
      end
   end

   assign event_ok = cfg_in.trig_on_line ? hs : (vs & field_ok);

   assign dly_done = (dly_cnt_q == '0) ||
                     (dly_cnt_q == 20'h0_0001 && (cfg_in.delay_unit_select ? 1'b1 : hs));
   assign auto_due = cfg_in.auto_mode && auto_cnt_q >= 24'(AUTO_CYC - 1);

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         state_q    <= VST_ST_ARMED;
         dly_cnt_q  <= '0;
         hold_cnt_q <= '0;
         auto_cnt_q <= '0;
      end else begin
         unique case (state_q)
            VST_ST_ARMED: begin
               auto_cnt_q <= auto_cnt_q + 24'h00_0001;
               if (event_ok) begin
                  auto_cnt_q <= '0;
                  dly_cnt_q  <= cfg_in.delay_amount;
                  state_q    <= VST_ST_DELAY;
                  if (cfg_in.delay_amount == '0) begin
                     hold_cnt_q <= holdoff_q;
                     state_q    <= VST_ST_HOLD;
                  end
               end else if (auto_due) begin
                  auto_cnt_q <= '0;
                  hold_cnt_q <= holdoff_q;
                  state_q    <= VST_ST_HOLD;
               end
            end
            VST_ST_DELAY: begin
               if (cfg_in.delay_unit_select || hs)
                  dly_cnt_q <= dly_cnt_q - 20'h0_0001;
               if (dly_done) begin
                  hold_cnt_q <= holdoff_q;
                  state_q    <= VST_ST_HOLD;
               end
            end
            VST_ST_HOLD: begin
               hold_cnt_q <= hold_cnt_q - 24'h00_0001;
               if (hold_cnt_q <= 24'h00_0001)
                  state_q <= VST_ST_ARMED;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in)
         want_odd_q <= 1'b1;
      else if (state_q == VST_ST_ARMED && event_ok && !cfg_in.trig_on_line)
         want_odd_q <= ~fo;
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         trig_out       <= 1'b0;
         acq_start_out  <= 1'b0;
         auto_fired_out <= 1'b0;
         armed_out      <= 1'b0;
      end else begin
         trig_out       <= 1'b0;
         acq_start_out  <= 1'b0;
         auto_fired_out <= 1'b0;
         armed_out      <= state_q == VST_ST_ARMED;
         if ((state_q == VST_ST_ARMED && event_ok && cfg_in.delay_amount == '0) ||
             (state_q == VST_ST_DELAY && dly_done)) begin
            trig_out      <= 1'b1;
            acq_start_out <= 1'b1;
         end else if (state_q == VST_ST_ARMED && !event_ok && auto_due) begin
            acq_start_out  <= 1'b1;
            auto_fired_out <= 1'b1;
         end
      end
   end

   assign field_odd_out   = fo;
   assign rate_out        = rate_q;
   assign period_ns_out   = period_q;
   assign holdoff_cyc_out = holdoff_q;

endmodule : vst_trigger

// file: logic/vst_params.svh
`ifndef VST_PARAMS_SVH
`define VST_PARAMS_SVH

// Reference clock period in ns (50 MHz).
`define VST_CLK_NS          20

// Standard classes: lines per frame and field rate.
`define VST_LINES_525       525
`define VST_FIELD_HZ_525    60
`define VST_LINES_625       625
`define VST_FIELD_HZ_625    50

// Line period in ns: two fields per frame.
`define VST_LINE_NS_525     (2000000000 / (`VST_LINES_525 * `VST_FIELD_HZ_525))
`define VST_LINE_NS_625     (2000000000 / (`VST_LINES_625 * `VST_FIELD_HZ_625))

// Custom scan period limits in ns.
`define VST_PERIOD_MIN_NS   15625
`define VST_PERIOD_MAX_NS   66667

// Least period of each scan-rate range in ns (64, 35, 25, 20 kHz).
`define VST_RATE4_MIN_NS    15625
`define VST_RATE3_MIN_NS    28572
`define VST_RATE2_MIN_NS    40000
`define VST_RATE1_MIN_NS    50000

// Custom period after reset in ns.
`define VST_PERIOD_RST_NS   63492

// Default holdoff per class and interlaced field, in us.
`define VST_HO_525_F1_US    16500
`define VST_HO_525_F2_US    16532
`define VST_HO_625_F1_US    19800
`define VST_HO_625_F2_US    19832
`define VST_HO_CUST_US      1000

// Auto-mode trigger timeout in us.
`define VST_AUTO_US         100000

`endif

// file: logic/vst_pkg.sv
package vst_pkg;

   typedef enum logic [1:0] {
      VST_CLASS_525,
      VST_CLASS_PAL,
      VST_CLASS_SECAM,
      VST_CLASS_CUSTOM
   } vst_class_e;

   typedef enum logic [1:0] {
      VST_FIELD_ODD,
      VST_FIELD_EVEN,
      VST_FIELD_ALL
   } vst_field_e;

   typedef enum logic [1:0] {
      VST_ILACE_F1,
      VST_ILACE_F2,
      VST_ILACE_BOTH
   } vst_ilace_e;

   typedef enum logic [1:0] {
      VST_RATE_1,
      VST_RATE_2,
      VST_RATE_3,
      VST_RATE_4
   } vst_rate_e;

   typedef enum logic [1:0] {
      VST_ST_ARMED,
      VST_ST_DELAY,
      VST_ST_HOLD
   } vst_state_e;

   typedef struct packed {
      vst_class_e  class_sel;
      vst_field_e  field_sel;
      vst_ilace_e  ilace_sel;
      logic [1:0]  src_sel;
      logic        sync_pos;
      logic        delay_unit_select;
      logic [19:0] delay_amount;
      logic        trig_on_line;
      logic        auto_mode;
   } vst_cfg_s;

endpackage : vst_pkg

// file: logic/vst_sync_sep.sv
`timescale 1ns/1ps

module vst_sync_sep #(
   parameter int PH_W = 12
) (
   // Clock and reset
   input  wire logic            ref_clk_in,
   input  wire logic            resetn_in,
   // Sync level, already polarity corrected
   input  wire logic            sync_lvl_in,
   input  wire logic [PH_W-1:0] line_cyc_in,
   // Separated events
   output logic                 hsync_out,
   output logic                 vsync_out,
   output logic                 field_odd_out
);

   logic            lvl_q;
   logic [PH_W-1:0] width_q;
   logic [PH_W-1:0] phase_q;
   logic [PH_W-1:0] start_ph_q;
   logic            vs_seen_q;
   logic            fall;
   logic            broad;
   logic            narrow_h;

   assign fall     = lvl_q & ~sync_lvl_in;
   // Broad pulses exceed a quarter line, line syncs exceed a twentieth.
   assign broad    = width_q > (line_cyc_in >> 2);
   assign narrow_h = ~broad && (width_q > line_cyc_in / PH_W'(20));

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         lvl_q   <= 1'b0;
         width_q <= '0;
      end else begin
         lvl_q <= sync_lvl_in;
         if (sync_lvl_in && !lvl_q)
            width_q <= PH_W'(1);
         else if (sync_lvl_in && width_q != '1)
            width_q <= width_q + PH_W'(1);
      end
   end

   // The phase wraps each line so half-line offsets stay visible through
   // the equalising pulses.
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         phase_q    <= '0;
         start_ph_q <= '0;
      end else begin
         if (fall && narrow_h)
            phase_q <= width_q;
         else if (phase_q >= line_cyc_in - PH_W'(1))
            phase_q <= '0;
         else
            phase_q <= phase_q + PH_W'(1);
         if (sync_lvl_in && !lvl_q)
            start_ph_q <= phase_q;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         hsync_out     <= 1'b0;
         vsync_out     <= 1'b0;
         vs_seen_q     <= 1'b0;
         field_odd_out <= 1'b1;
      end else begin
         hsync_out <= fall & narrow_h;
         vsync_out <= fall & broad & ~vs_seen_q;
         if (fall && narrow_h)
            vs_seen_q <= 1'b0;
         else if (fall && broad)
            vs_seen_q <= 1'b1;
         if (fall && broad && !vs_seen_q)
            field_odd_out <= !((start_ph_q >= (line_cyc_in >> 2)) &&
                               (start_ph_q < line_cyc_in - (line_cyc_in >> 2)));
      end
   end

endmodule : vst_sync_sep

// file: dv/vst_video_src.sv
`timescale 1ns/1ps

module vst_video_src #(
   parameter int LINE  = 3175,
   parameter int WIDTH = 300
) (
   // Clock
   input  wire logic       ref_clk_in,
   // Control
   input  wire logic       en_in,
   input  wire logic       broad_in,
   input  wire logic       pos_in,
   input  wire logic [1:0] ch_in,
   // Video
   output logic [3:0]      slice_out,
   output logic            end_out
);
   int   cnt_q   = 0;
   logic sync_q  = 1'b0;
   logic noise_q = 1'b0;

   always_ff @(posedge ref_clk_in) begin
      cnt_q   <= (en_in && cnt_q < LINE - 1) ? cnt_q + 1 : 0;
      // Broad pulses last four line-sync widths; the first of a run marks a field.
      sync_q  <= en_in && cnt_q < (broad_in ? 4 * WIDTH : WIDTH);
      end_out <= en_in && cnt_q == (broad_in ? 4 * WIDTH : WIDTH);
      noise_q <= ~noise_q;
   end

   // Unselected channels toggle every cycle, far too narrow for a sync.
   always_comb begin
      slice_out = {4{noise_q}};
      slice_out[ch_in] = sync_q ^ pos_in;
   end
endmodule : vst_video_src

// file: dv/vst_chk.sv
`timescale 1ns/1ps

module vst_chk
   import vst_pkg::*;
(
   // Clock and reset
   input wire logic        ref_clk_in,
   input wire logic        resetn_in,
   // Configuration
   input wire vst_cfg_s    cfg_in,
   input wire logic        period_wr_in,
   input wire logic        rate_wr_in,
   input wire vst_rate_e   rate_in,
   input wire logic        holdoff_wr_in,
   input wire logic [23:0] holdoff_cyc_in,
   // Outputs
   input wire logic        trig_out,
   input wire logic        acq_start_out,
   input wire logic        auto_fired_out,
   input wire vst_rate_e   rate_out,
   input wire logic [16:0] period_ns_out,
   input wire logic [23:0] holdoff_cyc_out
);
   logic [24:0] gap_q;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   function automatic vst_rate_e rate_of(input logic [16:0] p);
      return p >= 17'h0c350 ? VST_RATE_1 : p >= 17'h09c40 ? VST_RATE_2 :
             p >= 17'h06f9c ? VST_RATE_3 : VST_RATE_4;
   endfunction : rate_of

   // Cycles since the last acquisition start, saturating.
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         gap_q <= 25'h1000000;
      end else if (acq_start_out) begin
         gap_q <= 25'h0;
      end else if (gap_q < 25'h1000000) begin
         gap_q <= gap_q + 25'h1;
      end
   end

   a_trig_has_acq: assert property (trig_out |-> acq_start_out && !auto_fired_out)
      else $error("trigger without acquisition start");
   a_auto_has_acq: assert property (auto_fired_out |-> acq_start_out && $past(cfg_in.auto_mode))
      else $error("auto start without auto mode");
   a_acq_has_cause: assert property (acq_start_out |-> trig_out || auto_fired_out)
      else $error("acquisition start without cause");
   a_normal_no_auto: assert property (!cfg_in.auto_mode [*3] |-> !auto_fired_out)
      else $error("auto start in normal mode");
   a_pulse_single: assert property (acq_start_out |=> !acq_start_out)
      else $error("acquisition start longer than one cycle");
   a_hold_gap: assert property (acq_start_out |-> gap_q + 25'h1 >= {1'b0, holdoff_cyc_out})
      else $error("acquisition start inside holdoff");
   a_period_range: assert property (period_ns_out >= 17'h03d09 && period_ns_out <= 17'h1046b)
      else $error("scan period out of range");
   a_rate_follows: assert property (period_wr_in |=> rate_out == rate_of(period_ns_out))
      else $error("scan rate does not match period");
   a_rate_forces: assert property (rate_wr_in && !period_wr_in |=>
      rate_out == $past(rate_in) && rate_of(period_ns_out) == rate_out)
      else $error("period not forced into chosen range");
   a_holdoff_wr: assert property (holdoff_wr_in |=> holdoff_cyc_out ==
      ($past(holdoff_cyc_in) == 24'h0 ? 24'h1 : $past(holdoff_cyc_in)))
      else $error("holdoff write not taken");
   a_custom_reload: assert property ($changed(cfg_in.class_sel) && !holdoff_wr_in &&
      cfg_in.class_sel == VST_CLASS_CUSTOM |-> ##[1:2] holdoff_cyc_out == 24'h00c350)
      else $error("custom holdoff default not loaded");

   c_trig: cover property (trig_out);
   c_auto: cover property (auto_fired_out);
   c_rate_wr: cover property (rate_wr_in ##1 period_ns_out == 17'h03d09);
endmodule : vst_chk

bind vst_trigger vst_chk chk_u (
   .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .cfg_in(cfg_in),
   .period_wr_in(period_wr_in), .rate_wr_in(rate_wr_in), .rate_in(rate_in),
   .holdoff_wr_in(holdoff_wr_in), .holdoff_cyc_in(holdoff_cyc_in), .trig_out(trig_out),
   .acq_start_out(acq_start_out), .auto_fired_out(auto_fired_out), .rate_out(rate_out),
   .period_ns_out(period_ns_out), .holdoff_cyc_out(holdoff_cyc_out)
);

// file: dv/testbench.sv
`timescale 1ns/1ps

module testbench
   import vst_pkg::*;
;
   typedef struct packed {
      int   lo;
      int   hi;
      logic auto_f;
   } vst_note_s;

   logic        ref_clk_in = 1'b0;
   logic        resetn_in  = 1'b0;
   vst_cfg_s    cfg        = '0;
   logic        period_wr  = 1'b0;
   logic [16:0] period_ns  = '0;
   logic        rate_wr    = 1'b0;
   vst_rate_e   rate       = VST_RATE_1;
   logic        ho_wr      = 1'b0;
   logic [23:0] ho_cyc     = '0;
   logic        src_en     = 1'b0;
   logic        broad      = 1'b0;
   logic [3:0]  slice;
   logic        src_end, trig, acq, auto_f, armed;
   vst_rate_e   rate_o, exp_r, r;
   logic [16:0] period_o, exp_p, p;
   logic [23:0] ho_o;
   vst_note_s   notes[$];
   vst_note_s   mon_n;
   int          cyc = 0;
   int          mismatches = 0;
   int          checks = 0;
   logic [16:0] rmin [4] = '{17'h0c350, 17'h09c40, 17'h06f9c, 17'h03d09};
   vst_class_e  cls  [4] = '{VST_CLASS_PAL, VST_CLASS_SECAM, VST_CLASS_CUSTOM, VST_CLASS_525};
   logic [23:0] hod  [4] = '{24'h0f1b30, 24'h0f1b30, 24'h00c350, 24'h0c96a8};

   vst_trigger #(.NCH(4), .AUTO_CYC(200)) dut_u (
      .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .sync_slice_in(slice), .cfg_in(cfg),
      .period_wr_in(period_wr), .period_ns_in(period_ns), .rate_wr_in(rate_wr), .rate_in(rate),
      .holdoff_wr_in(ho_wr), .holdoff_cyc_in(ho_cyc), .trig_out(trig), .acq_start_out(acq),
      .auto_fired_out(auto_f), .armed_out(armed), .field_odd_out(), .rate_out(rate_o),
      .period_ns_out(period_o), .holdoff_cyc_out(ho_o));

   vst_video_src src_u (.ref_clk_in(ref_clk_in), .en_in(src_en), .broad_in(broad),
      .pos_in(cfg.sync_pos),
      .ch_in(cfg.src_sel), .slice_out(slice), .end_out(src_end));

   initial begin
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic results();
      $display("Checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   function automatic vst_rate_e rate_of(input logic [16:0] v);
      return v >= 17'h0c350 ? VST_RATE_1 : v >= 17'h09c40 ? VST_RATE_2 :
             v >= 17'h06f9c ? VST_RATE_3 : VST_RATE_4;
   endfunction : rate_of

   task automatic wr_cfg(input logic pw, input logic rw);
      @(posedge ref_clk_in);
      period_wr <= pw;
      period_ns <= p;
      rate_wr   <= rw;
      rate      <= r;
      @(posedge ref_clk_in);
      period_wr <= 1'b0;
      rate_wr   <= 1'b0;
      @(posedge ref_clk_in);
      #1;
      chk("rate", exp_r, rate_o);
      chk("period", exp_p, period_o);
   endtask : wr_cfg

   task automatic ho(input logic [23:0] v);
      @(posedge ref_clk_in);
      ho_wr  <= 1'b1;
      ho_cyc <= v;
      @(posedge ref_clk_in);
      ho_wr <= 1'b0;
      @(posedge ref_clk_in);
      #1;
      chk("holdoff", v == 24'h0 ? 24'h1 : v, ho_o);
   endtask : ho

   // Runs n lines; a trigger is noted for lines where i % step equals ph.
   task automatic lines(input int n, input int step, input int ph, input int off);
      @(posedge ref_clk_in);
      src_en <= 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk_in);
         while (src_end !== 1'b1) @(posedge ref_clk_in);
         if (i % step == ph) notes.push_back('{cyc + off - 1, cyc + off + 4, 1'b0});
      end
      src_en <= 1'b0;
      repeat (4000) @(posedge ref_clk_in);
   endtask : lines

   always @(posedge ref_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         mismatches++;
         results();
      end
   end

   always @(posedge ref_clk_in) begin
      if (resetn_in && acq === 1'b1) begin
         if (notes.size() == 0) begin
            chk("acq_unexpected", 0, 1);
         end else begin
            mon_n = notes.pop_front();
            chk("acq_time", 1, cyc >= mon_n.lo && cyc <= mon_n.hi);
            chk("auto_fired", mon_n.auto_f, auto_f);
            chk("trig", !mon_n.auto_f, trig);
         end
      end
   end

   initial begin
      void'($urandom(32));
      repeat (20) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      #1;
      chk("armed", 1, armed);
      chk("holdoff_reset", 24'h0c96a8, ho_o);
      chk("period_reset", 17'h0f804, period_o);
      chk("rate_reset", VST_RATE_1, rate_o);
      p = '0;
      r = VST_RATE_4;
      exp_p = 17'h03d09;
      exp_r = VST_RATE_4;
      wr_cfg(1'b0, 1'b1);
      for (int i = 0; i < 12; i++) begin
         p = 17'(10000 + $urandom_range(0, 70000));
         r = vst_rate_e'($urandom_range(0, 3));
         if (i % 2 == 0) begin
            exp_p = p < 17'h03d09 ? 17'h03d09 : p > 17'h1046b ? 17'h1046b : p;
            exp_r = rate_of(exp_p);
            wr_cfg(1'b1, 1'b0);
         end else begin
            if (rate_of(exp_p) != r) exp_p = rmin[r];
            exp_r = r;
            wr_cfg(1'b0, 1'b1);
         end
      end
      foreach (cls[i]) begin
         @(posedge ref_clk_in);
         cfg.class_sel <= cls[i];
         repeat (3) @(posedge ref_clk_in);
         #1;
         chk("holdoff_default", hod[i], ho_o);
      end
      ho(24'h0);
      ho(24'h000064);
      cfg.trig_on_line <= 1'b1;
      cfg.src_sel <= 2'($urandom_range(0, 3));
      lines(3, 1, 0, 0);
      ho(24'h000fa0);
      lines(4, 2, 0, 0);
      ho(24'h000064);
      cfg.delay_amount <= 20'h00002;
      lines(3, 3, 2, 0);
      cfg.delay_unit_select <= 1'b1;
      cfg.delay_amount <= 20'h001f4;
      lines(2, 1, 0, 500);
      cfg.delay_amount <= '0;
      cfg.sync_pos <= 1'b1;
      cfg.src_sel <= 2'($urandom_range(0, 3));
      lines(2, 1, 0, 0);
      cfg.class_sel <= VST_CLASS_CUSTOM;
      cfg.ilace_sel <= VST_ILACE_BOTH;
      cfg.trig_on_line <= 1'b0;
      broad <= 1'b1;
      ho(24'h000064);
      lines(2, 2, 0, 0);
      cfg.auto_mode <= 1'b1;
      notes.push_back('{cyc, cyc + 210, 1'b1});
      for (int i = 0; i < 400 && notes.size() > 0; i++) @(posedge ref_clk_in);
      cfg.auto_mode <= 1'b0;
      repeat (600) @(posedge ref_clk_in);
      chk("notes_left", 0, notes.size());
      results();
   end
endmodule : testbench
